// ### shared/iap_pkg.sv
package iap_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PTR_W   = 12;
  localparam int HI_W    = 4;
  localparam int LO_W    = 8;
  localparam int IDX_W   = 12;
  localparam int AXI_A_W = 14;
  localparam int NPTR    = 3;
  localparam int NMODE   = 5;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [11:0] PTR2_LOW_BYTE       = 12'hFD9;
  localparam logic [11:0] PTR2_HIGH_PART      = 12'hFDA;
  localparam logic [11:0] PTR2_OFFSET_ACCESS  = 12'hFDB;
  localparam logic [11:0] PTR2_PREINC_ACCESS  = 12'hFDC;
  localparam logic [11:0] PTR2_POSTDEC_ACCESS = 12'hFDD;
  localparam logic [11:0] PTR2_POSTINC_ACCESS = 12'hFDE;
  localparam logic [11:0] PTR2_PLAIN_ACCESS   = 12'hFDF;
  localparam logic [11:0] BANK_SELECT         = 12'hFE0;
  localparam logic [11:0] PTR1_LOW_BYTE       = 12'hFE1;
  localparam logic [11:0] PTR1_HIGH_PART      = 12'hFE2;
  localparam logic [11:0] PTR1_OFFSET_ACCESS  = 12'hFE3;
  localparam logic [11:0] PTR1_PREINC_ACCESS  = 12'hFE4;
  localparam logic [11:0] PTR1_POSTDEC_ACCESS = 12'hFE5;
  localparam logic [11:0] PTR1_POSTINC_ACCESS = 12'hFE6;
  localparam logic [11:0] PTR1_PLAIN_ACCESS   = 12'hFE7;
  localparam logic [11:0] WORKING_ACCUMULATOR = 12'hFE8;
  localparam logic [11:0] PTR0_LOW_BYTE       = 12'hFE9;
  localparam logic [11:0] PTR0_HIGH_PART      = 12'hFEA;
  localparam logic [11:0] PTR0_OFFSET_ACCESS  = 12'hFEB;
  localparam logic [11:0] PTR0_PREINC_ACCESS  = 12'hFEC;
  localparam logic [11:0] PTR0_POSTDEC_ACCESS = 12'hFED;
  localparam logic [11:0] PTR0_POSTINC_ACCESS = 12'hFEE;
  localparam logic [11:0] PTR0_PLAIN_ACCESS   = 12'hFEF;
  localparam logic [11:0] LAST_ADDRESS        = 12'hF00;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [11:0] PTR_RST  = 12'h000;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [7:0]  WORK_RST = 8'h00;

  // ************************************************************
  // AXI responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_PLAIN,
    MODE_POSTINC,
    MODE_POSTDEC,
    MODE_PREINC,
    MODE_OFFSET
  } access_mode_t;

  typedef struct packed {
    logic         acc;
    access_mode_t mode;
    logic         wr_lo;
    logic         wr_hi;
    logic [7:0]   data;
  } ptr_cmd_t;

endpackage

// ### rtl/ptr_unit.sv
`timescale 1ns/1ns
module ptr_unit (
  input  wire logic                           aclk,     // Core clock
  input  wire logic                           aresetn,  // Sync reset
  input  wire logic                           ce,       // Clock enable
  input  wire iap_pkg::ptr_cmd_t              cmd,      // Access command
  input  wire logic [7:0]                     offset,   // Working value
  output logic      [iap_pkg::PTR_W-1:0]      ptr,      // Pointer value
  output logic      [iap_pkg::PTR_W-1:0]      eff_addr  // Access address
);

  logic [iap_pkg::PTR_W-1:0] ptr_r;
  logic [iap_pkg::PTR_W-1:0] ptr_inc;
  logic [iap_pkg::PTR_W-1:0] ptr_dec;
  logic [iap_pkg::PTR_W-1:0] ptr_off;

  // ************************************************************
  // Address forming
  // ************************************************************
  assign ptr     = ptr_r;
  assign ptr_inc = ptr_r + 12'h001;                              // [RL7]
  assign ptr_dec = ptr_r - 12'h001;                              // [RL7]
  assign ptr_off = ptr_r + {{4{offset[7]}}, offset};     // [RL3] [RL5]

  always_comb begin
    unique case (cmd.mode)
      iap_pkg::MODE_PREINC: eff_addr = ptr_inc;
      iap_pkg::MODE_OFFSET: eff_addr = ptr_off;                 // [RL3]
      default:              eff_addr = ptr_r;              // [RL1] [RL2]
    endcase
  end

  // ************************************************************
  // Pointer update
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= iap_pkg::PTR_RST;                                 // [RL6]
    end else if (ce) begin
      if (cmd.wr_lo) begin
        ptr_r[7:0] <= cmd.data;
      end else if (cmd.wr_hi) begin
        ptr_r[11:8] <= cmd.data[3:0];                            // [RL6]
      end else if (cmd.acc) begin
        unique case (cmd.mode)
          iap_pkg::MODE_POSTINC,
          iap_pkg::MODE_PREINC:  ptr_r <= ptr_inc;               // [RL7]
          iap_pkg::MODE_POSTDEC: ptr_r <= ptr_dec;               // [RL1]
          default:               ptr_r <= ptr_r;
        endcase
      end
    end
  end

endmodule

// ### rtl/indirect_address_pointers.sv
// Overview of operation
// (RL1) Pointer 0 post-decrement location uses pointer, then decrements it.
// (RL2) Pointer 0 locations address memory from pointer contents, not the opcode.
// (RL3) Pointer 0 offset location addresses pointer plus working value.
// (RL4) Virtual locations store nothing; reads and writes reach data memory.
// (RL5) Pointer 2 offset location addresses pointer plus working value.
// (RL6) Pointer high parts hold four bits, reset zero, upper bits read zero.
// (RL7) Each pointer has five access modes; updates carry across all 12 bits.
`timescale 1ns/1ns
module indirect_address_pointers #(
  parameter int DEPTH = 4096  // Data memory bytes
) (
  input  wire logic        aclk,           // Core clock
  input  wire logic        aresetn,        // Sync reset, active low
  input  wire logic        ce,             // Clock enable
  input  wire logic [13:0] s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [13:0] s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready    // Read data ready
);

  // ************************************************************
  // Index tables
  // ************************************************************
  localparam logic [11:0] IDX_LO [3] = '{
    iap_pkg::PTR0_LOW_BYTE,
    iap_pkg::PTR1_LOW_BYTE,
    iap_pkg::PTR2_LOW_BYTE
  };
  localparam logic [11:0] IDX_HI [3] = '{
    iap_pkg::PTR0_HIGH_PART,
    iap_pkg::PTR1_HIGH_PART,
    iap_pkg::PTR2_HIGH_PART
  };
  // Ordered as access_mode_t
  localparam logic [11:0] IDX_ACC [3][5] = '{
    '{iap_pkg::PTR0_PLAIN_ACCESS,   iap_pkg::PTR0_POSTINC_ACCESS,
      iap_pkg::PTR0_POSTDEC_ACCESS, iap_pkg::PTR0_PREINC_ACCESS,
      iap_pkg::PTR0_OFFSET_ACCESS},
    '{iap_pkg::PTR1_PLAIN_ACCESS,   iap_pkg::PTR1_POSTINC_ACCESS,
      iap_pkg::PTR1_POSTDEC_ACCESS, iap_pkg::PTR1_PREINC_ACCESS,
      iap_pkg::PTR1_OFFSET_ACCESS},
    '{iap_pkg::PTR2_PLAIN_ACCESS,   iap_pkg::PTR2_POSTINC_ACCESS,
      iap_pkg::PTR2_POSTDEC_ACCESS, iap_pkg::PTR2_PREINC_ACCESS,
      iap_pkg::PTR2_OFFSET_ACCESS}
  };

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]               mem [DEPTH];
  logic                     aw_full_r;
  logic [11:0]              aw_idx_r;
  logic                     w_full_r;
  logic [7:0]               w_data_r;
  logic                     w_lane0_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     rvalid_r;
  logic [31:0]              rdata_r;
  logic [1:0]               rresp_r;
  logic [7:0]               work_r;
  logic [3:0]               bank_r;
  logic [11:0]              last_addr_r;
  logic                     wr_go;
  logic                     rd_go;
  logic                     wr_en;
  logic [11:0]              idx;
  logic                     dec_hit;
  logic                     dec_lo;
  logic                     dec_hi;
  logic                     dec_acc;
  logic                     dec_bank;
  logic                     dec_work;
  logic                     dec_last;
  logic [1:0]               dec_ptr;
  iap_pkg::access_mode_t    dec_mode;
  iap_pkg::ptr_cmd_t        cmd [3];
  logic [11:0]              ptr_val [3];
  logic [11:0]              ptr_eff [3];
  logic [11:0]              eff;
  logic [31:0]              rd_val;

  // ************************************************************
  // Channel handshakes
  // ************************************************************
  assign s_axi_awready = ce && !aw_full_r;
  assign s_axi_wready  = ce && !w_full_r;
  assign wr_go         = ce && aw_full_r && w_full_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r && !wr_go;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign wr_en         = wr_go && w_lane0_r;

  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_idx_r  <= 12'h000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[13:2];
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  // Write data holding; only byte lane 0 carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r  <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Index decode
  // ************************************************************
  assign idx = wr_go ? aw_idx_r : s_axi_araddr[13:2];

  always_comb begin
    dec_lo   = 1'b0;
    dec_hi   = 1'b0;
    dec_acc  = 1'b0;
    dec_ptr  = 2'h0;
    dec_mode = iap_pkg::MODE_PLAIN;
    for (int k = 0; k < iap_pkg::NPTR; k++) begin
      if (idx == IDX_LO[k]) begin
        dec_lo  = 1'b1;
        dec_ptr = 2'(k);
      end
      if (idx == IDX_HI[k]) begin
        dec_hi  = 1'b1;
        dec_ptr = 2'(k);
      end
      for (int m = 0; m < iap_pkg::NMODE; m++) begin
        if (idx == IDX_ACC[k][m]) begin
          dec_acc  = 1'b1;                                       // [RL7]
          dec_ptr  = 2'(k);
          dec_mode = iap_pkg::access_mode_t'(m);
        end
      end
    end
    dec_bank = (idx == iap_pkg::BANK_SELECT);
    dec_work = (idx == iap_pkg::WORKING_ACCUMULATOR);
    dec_last = (idx == iap_pkg::LAST_ADDRESS);
    dec_hit  = dec_lo || dec_hi || dec_acc || dec_bank || dec_work
               || dec_last;
  end

  // ************************************************************
  // Pointer units
  // ************************************************************
  generate
    for (genvar k = 0; k < iap_pkg::NPTR; k++) begin : g_ptr
      always_comb begin
        cmd[k].acc   = (wr_en || rd_go) && dec_acc
                       && (dec_ptr == 2'(k));                    // [RL7]
        cmd[k].mode  = dec_mode;
        cmd[k].wr_lo = wr_en && dec_lo && (dec_ptr == 2'(k));
        cmd[k].wr_hi = wr_en && dec_hi && (dec_ptr == 2'(k));
        cmd[k].data  = w_data_r;
      end

      ptr_unit u_ptr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .cmd      (cmd[k]),
        .offset   (work_r),                              // [RL3] [RL5]
        .ptr      (ptr_val[k]),
        .eff_addr (ptr_eff[k])
      );
    end
  endgenerate

  // Effective address always comes from the pointer, never the index
  assign eff = ptr_eff[dec_ptr];                                 // [RL2]

  // ************************************************************
  // Data memory
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (ce && wr_en && dec_acc) begin
      mem[eff] <= w_data_r;                                      // [RL4]
    end
  end

  // Address of the most recent indirect access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_addr_r <= iap_pkg::PTR_RST;
    end else if (ce && (wr_en || rd_go) && dec_acc) begin
      last_addr_r <= eff;                                        // [RL1]
    end
  end

  // ************************************************************
  // Working and bank registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_r <= iap_pkg::WORK_RST;
    end else if (ce && wr_en && dec_work) begin
      work_r <= w_data_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_r <= iap_pkg::BANK_RST;
    end else if (ce && wr_en && dec_bank) begin
      bank_r <= w_data_r[3:0];
    end
  end

  // ************************************************************
  // Read data select
  // ************************************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    if (dec_acc) begin
      rd_val = {24'h00_0000, mem[eff]};                          // [RL4]
    end else if (dec_lo) begin
      rd_val = {24'h00_0000, ptr_val[dec_ptr][7:0]};
    end else if (dec_hi) begin
      rd_val = {28'h000_0000, ptr_val[dec_ptr][11:8]};           // [RL6]
    end else if (dec_bank) begin
      rd_val = {28'h000_0000, bank_r};
    end else if (dec_work) begin
      rd_val = {24'h00_0000, work_r};
    end else if (dec_last) begin
      rd_val = {20'h0_0000, last_addr_r};
    end
  end

  // ************************************************************
  // Responses
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= iap_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= dec_hit ? iap_pkg::RESP_OKAY
                            : iap_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= iap_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= dec_hit ? iap_pkg::RESP_OKAY
                            : iap_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule

// ### tb/iap_assertions.sv
`timescale 1ns/1ns
module iap_checker (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, active low
  input wire logic        ce,            // Clock enable
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic [1:0]  s_axi_bresp,   // Write response
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic [1:0]  s_axi_rresp,   // Read response
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready   // Read data ready
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
     && !s_axi_bvalid) ##1 ce |=> s_axi_bvalid)
    else $error("write answer late");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_error_data: assert property (
    s_axi_rvalid && s_axi_rresp == iap_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h00000000)
    else $error("error read carries data");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_ce_freeze: assert property (
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready while clock enable low");
endmodule

bind indirect_address_pointers iap_checker i_iap_checker (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);

// ### tb/core_model.sv
`timescale 1ns/1ns
module core_model (
  input  wire logic        aclk,          // Clock
  output logic      [13:0] s_axi_awaddr,  // Write address
  output logic             s_axi_awvalid, // Write address valid
  input  wire logic        s_axi_awready, // Write address ready
  output logic      [31:0] s_axi_wdata,   // Write data
  output logic      [3:0]  s_axi_wstrb,   // Write strobes
  output logic             s_axi_wvalid,  // Write data valid
  input  wire logic        s_axi_wready,  // Write data ready
  input  wire logic [1:0]  s_axi_bresp,   // Write response
  input  wire logic        s_axi_bvalid,  // Write response valid
  output logic             s_axi_bready,  // Write response ready
  output logic      [13:0] s_axi_araddr,  // Read address
  output logic             s_axi_arvalid, // Read address valid
  input  wire logic        s_axi_arready, // Read address ready
  input  wire logic [31:0] s_axi_rdata,   // Read data
  input  wire logic [1:0]  s_axi_rresp,   // Read response
  input  wire logic        s_axi_rvalid,  // Read data valid
  output logic             s_axi_rready   // Read data ready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  // Each channel is judged at the rising edge at which it is taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] resp);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    logic r;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        r = 1'b1;
      end
    end
  endtask
endmodule

// ### tb/indirect_address_pointers_tb_top.sv
`timescale 1ns/1ns
module indirect_address_pointers_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errors = 0;
  int          comparisons = 0;

  always #5 aclk = ~aclk;

  indirect_address_pointers i_indirect_address_pointers (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  core_model i_core_model (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic wr(input logic [11:0] i, input logic [7:0] d,
                    input logic [3:0] s = 4'h1,
                    input logic [1:0] e = iap_pkg::RESP_OKAY);
    logic [1:0] r;
    i_core_model.wr(i, d, s, r);
    comparisons++;
    if (r !== e) begin
      errors++;
      $display("ERROR %0t write resp idx %h", $time, i);
    end
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] x,
                    input logic [1:0] e = iap_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    i_core_model.rd(i, d, r);
    comparisons++;
    if (d !== x || r !== e) begin
      errors++;
      $display("ERROR %0t read idx %h got %h exp %h", $time, i, d, x);
    end
  endtask

  task automatic set_ptr(input logic [11:0] b, input logic [11:0] v);
    wr(b, v[7:0]);
    wr(b + 12'h001, {4'h0, v[11:8]});
  endtask

  task automatic chk_ptr(input logic [11:0] b, input logic [11:0] v);
    rd(b, {24'h000000, v[7:0]});
    rd(b + 12'h001, {28'h0000000, v[11:8]});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values();
    rd(iap_pkg::PTR0_HIGH_PART, 32'h00000000);
    rd(iap_pkg::PTR1_HIGH_PART, 32'h00000000);
    rd(iap_pkg::PTR2_HIGH_PART, 32'h00000000);
    wr(iap_pkg::PTR0_HIGH_PART, 8'hFF);
    rd(iap_pkg::PTR0_HIGH_PART, 32'h0000000F);
  endtask

  // Offsets from a pointer's low byte: 2 offset, 3 preinc, 4 postdec,
  // 5 postinc, 6 plain
  task automatic t_modes();
    logic [11:0] b;
    logic [7:0]  p;
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? iap_pkg::PTR0_LOW_BYTE :
          (k == 1) ? iap_pkg::PTR1_LOW_BYTE : iap_pkg::PTR2_LOW_BYTE;
      p = 8'(k);
      set_ptr(b, 12'h2FF);
      wr(b + 12'h005, 8'h10 + p);
      chk_ptr(b, 12'h300);
      wr(b + 12'h003, 8'h20 + p);
      chk_ptr(b, 12'h301);
      rd(b + 12'h004, 32'(8'h20 + p));
      wr(b + 12'h004, 8'h30 + p);
      chk_ptr(b, 12'h2FF);
      rd(b + 12'h006, 32'(8'h10 + p));
      rd(b + 12'h005, 32'(8'h10 + p));
      rd(b + 12'h006, 32'(8'h30 + p));
      chk_ptr(b, 12'h300);
    end
  endtask

  task automatic t_offset();
    wr(iap_pkg::WORKING_ACCUMULATOR, 8'h05);
    set_ptr(iap_pkg::PTR0_LOW_BYTE, 12'h0FE);
    wr(iap_pkg::PTR0_OFFSET_ACCESS, 8'h3C);
    set_ptr(iap_pkg::PTR1_LOW_BYTE, 12'h103);
    rd(iap_pkg::PTR1_PLAIN_ACCESS, 32'h0000003C);
    chk_ptr(iap_pkg::PTR0_LOW_BYTE, 12'h0FE);
    wr(iap_pkg::WORKING_ACCUMULATOR, 8'hFF);
    set_ptr(iap_pkg::PTR2_LOW_BYTE, 12'h104);
    wr(iap_pkg::PTR2_OFFSET_ACCESS, 8'h77);
    rd(iap_pkg::PTR1_PLAIN_ACCESS, 32'h00000077);
    rd(iap_pkg::PTR2_OFFSET_ACCESS, 32'h00000077);
    chk_ptr(iap_pkg::PTR2_LOW_BYTE, 12'h104);
  endtask

  task automatic t_bus_edges();
    rd(12'h010, 32'h00000000, iap_pkg::RESP_SLVERR);
    wr(12'h010, 8'h5A, 4'h1, iap_pkg::RESP_SLVERR);
    wr(iap_pkg::PTR0_LOW_BYTE, 8'h55, 4'h0);
    rd(iap_pkg::PTR0_LOW_BYTE, 32'h000000FE);
    wr(iap_pkg::BANK_SELECT, 8'hFF);
    rd(iap_pkg::BANK_SELECT, 32'h0000000F);
    wr(iap_pkg::PTR0_PLAIN_ACCESS, 8'h66);
    rd(iap_pkg::LAST_ADDRESS, 32'h000000FE);
    rd(iap_pkg::PTR0_PLAIN_ACCESS, 32'h00000066);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    rd(iap_pkg::WORKING_ACCUMULATOR, 32'h000000FF);
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_modes();
    t_offset();
    t_bus_edges();
    complete_run();
  end
endmodule
